// ---- src/pwmc_map.svh ----
// register offsets, field positions and reset values of the pwm channel
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH

`define PWMC_OFF_CTRL 2'h0
`define PWMC_OFF_DCH 2'h1
`define PWMC_OFF_DCL 2'h2

`define PWMC_CTRL_EN 7
`define PWMC_CTRL_OE 6
`define PWMC_CTRL_FLAG 5
`define PWMC_CTRL_INV 4
`define PWMC_CTRL_RST 4'h0
`define PWMC_DCL_HI 7
`define PWMC_DCL_LO 6

`define PWMC_PHASE_ZERO 2'h0
`define PWMC_PHASE_ONE 2'h1
`define PWMC_PHASE_LAST 2'h3
`define PWMC_BYTE_ZERO 8'h00
`define PWMC_DUTY_ZERO 10'h000

`endif

// ---- src/pwmc_pkg.sv ----
// shared types of the pwm channel
package pwmc_pkg;
   typedef logic [7:0] pwmc_byte_t;
   typedef logic [1:0] pwmc_addr_t;
   typedef logic [9:0] pwmc_duty_t;
endpackage : pwmc_pkg

// ---- src/pwmc_timebase.sv ----
// ten-bit time base built from the shared period timer and a two-bit phase
`include "pwmc_map.svh"
module pwmc_timebase (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire pwmc_pkg::pwmc_byte_t period_timer_count_i,
   input wire pwmc_pkg::pwmc_byte_t period_limit_i,
   input wire logic prescale_tick_i,
   input wire logic sleep_i,
   output pwmc_pkg::pwmc_duty_t time_base_o,
   output logic period_end_o
);
   import pwmc_pkg::*;

   logic [1:0] phase_r;
   logic [1:0] phase_nxt;
   logic step;

   // phase only moves on a prescaled tick and never in sleep
   assign step = prescale_tick_i && !sleep_i;
   assign phase_nxt = step ? phase_r + `PWMC_PHASE_ONE : phase_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_r <= `PWMC_PHASE_ZERO;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // timer count supplies the upper eight bits
   assign time_base_o = {period_timer_count_i, phase_r};
   // the last phase of the limit count: the timer clears on this step
   assign period_end_o = step && (phase_r == `PWMC_PHASE_LAST) && (period_timer_count_i == period_limit_i);

   AST_PHASE_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      step |=> phase_r == $past(phase_r) + `PWMC_PHASE_ONE)
      else $error("time base phase did not advance on tick");
   AST_PHASE_SLEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sleep_i |=> $stable(phase_r))
      else $error("time base phase moved in sleep");
endmodule : pwmc_timebase

// ---- src/pwmc_channel.sv ----
// control and duty registers of one pwm channel with compare and pin drive
`include "pwmc_map.svh"
module pwmc_channel (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire pwmc_pkg::pwmc_addr_t addr_i,
   input wire pwmc_pkg::pwmc_byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output pwmc_pkg::pwmc_byte_t rdata_o,
   input wire pwmc_pkg::pwmc_byte_t period_timer_count_i,
   input wire pwmc_pkg::pwmc_byte_t period_limit_i,
   input wire logic prescale_tick_i,
   input wire logic sleep_i,
   output logic pwm_pin_o,
   output logic pwm_pin_oe_o
);
   import pwmc_pkg::*;

   logic [3:0] ctrl_r;
   pwmc_byte_t duty_high_byte_r;
   logic [1:0] duty_low_pair_r;
   pwmc_duty_t duty_buf_r;
   logic chan_out_r;
   logic chan_out_nxt;
   pwmc_byte_t rdata_nxt;
   pwmc_duty_t time_base;
   logic period_end;
   logic pwm_unit_enable;
   logic output_invert;

   // register access decode for writes and reads, shared by the control and duty write processes and the read mux
   function automatic logic hit(input pwmc_addr_t a, input pwmc_addr_t off, input logic strobe);
      hit = strobe && (a == off);
   endfunction : hit

   pwmc_timebase u_timebase (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .period_timer_count_i(period_timer_count_i),
      .period_limit_i(period_limit_i),
      .prescale_tick_i(prescale_tick_i),
      .sleep_i(sleep_i),
      .time_base_o(time_base),
      .period_end_o(period_end)
   );

   // control holds bits 7:4: enable, drive, the unused flag slot, invert; cleared on every reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `PWMC_CTRL_RST;
      end else if (hit(addr_i, `PWMC_OFF_CTRL, wr_i)) begin
         ctrl_r <= wdata_i[`PWMC_CTRL_EN:`PWMC_CTRL_INV];
      end
   end

   assign pwm_unit_enable = ctrl_r[`PWMC_CTRL_EN - `PWMC_CTRL_INV];
   assign output_invert = ctrl_r[0];
   // pin enable comes straight from the control flop
   assign pwm_pin_oe_o = ctrl_r[`PWMC_CTRL_OE - `PWMC_CTRL_INV];

   // duty registers carry no reset so they survive warm resets
   always_ff @(posedge clk_i) begin
      if (hit(addr_i, `PWMC_OFF_DCH, wr_i)) begin
         duty_high_byte_r <= wdata_i;
      end
      if (hit(addr_i, `PWMC_OFF_DCL, wr_i)) begin
         duty_low_pair_r <= wdata_i[`PWMC_DCL_HI:`PWMC_DCL_LO];
      end
   end

   // compare buffer only moves at the period limit match
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         duty_buf_r <= `PWMC_DUTY_ZERO;
      end else if (period_end) begin
         duty_buf_r <= {duty_high_byte_r, duty_low_pair_r};
      end
   end

   // set at restart unless new duty is zero, clear on equality
   always_comb begin
      chan_out_nxt = chan_out_r;
      if (!pwm_unit_enable) begin
         chan_out_nxt = 1'b0;
      end else if (sleep_i) begin
         chan_out_nxt = chan_out_r;
      end else if (period_end) begin
         chan_out_nxt = ({duty_high_byte_r, duty_low_pair_r} != `PWMC_DUTY_ZERO);
      end else if (time_base == duty_buf_r) begin
         chan_out_nxt = 1'b0;
      end
   end

   // disable also wins in sleep so an off channel never stays active
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_out_r <= 1'b0;
      end else begin
         chan_out_r <= chan_out_nxt;
      end
   end

   // pin level after polarity, one cycle behind the channel; frozen in sleep
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_pin_o <= 1'b0;
      end else if (!sleep_i) begin
         pwm_pin_o <= chan_out_r ^ output_invert;
      end
   end

   // read mux; unmapped offsets and unimplemented bits read zero
   always_comb begin
      rdata_nxt = `PWMC_BYTE_ZERO;
      if (hit(addr_i, `PWMC_OFF_CTRL, rd_i)) begin
         rdata_nxt[`PWMC_CTRL_EN:`PWMC_CTRL_INV] = ctrl_r;
         rdata_nxt[`PWMC_CTRL_FLAG] = pwm_pin_o;
      end else if (hit(addr_i, `PWMC_OFF_DCH, rd_i)) begin
         rdata_nxt = duty_high_byte_r;
      end else if (hit(addr_i, `PWMC_OFF_DCL, rd_i)) begin
         rdata_nxt[`PWMC_DCL_HI:`PWMC_DCL_LO] = duty_low_pair_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= `PWMC_BYTE_ZERO;
      end else begin
         rdata_o <= rdata_nxt;
      end
   end

   // restart step of an enabled, awake channel with nonzero new duty
   sequence seq_restart;
      pwm_unit_enable && !sleep_i && period_end && ({duty_high_byte_r, duty_low_pair_r} != `PWMC_DUTY_ZERO);
   endsequence
   sequence seq_ctrl_read;
      hit(addr_i, `PWMC_OFF_CTRL, rd_i);
   endsequence

   AST_EN_OFF_INACTIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !pwm_unit_enable |=> (!chan_out_r and (!sleep_i |=> pwm_pin_o == $past(output_invert))))
      else $error("disabled channel not inactive");
   AST_OE_FROM_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hit(addr_i, `PWMC_OFF_CTRL, wr_i) |=> pwm_pin_oe_o == $past(wdata_i[`PWMC_CTRL_OE]))
      else $error("pin enable does not follow control write");
   AST_POLARITY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !sleep_i |=> pwm_pin_o == ($past(chan_out_r) ^ $past(output_invert)))
      else $error("pin level does not match polarity");
   AST_FLAG_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_ctrl_read |=> rdata_o[`PWMC_CTRL_FLAG] == $past(pwm_pin_o) && rdata_o[3:0] == 4'h0)
      else $error("control read shows wrong flag or nonzero low bits");
   AST_DCL_LOW_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hit(addr_i, `PWMC_OFF_DCL, rd_i) |=> rdata_o[5:0] == 6'h00)
      else $error("duty low unimplemented bits not zero");
   AST_BUF_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      period_end |=> duty_buf_r == {$past(duty_high_byte_r), $past(duty_low_pair_r)})
      else $error("compare buffer not loaded at period match");
   AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !period_end |=> $stable(duty_buf_r))
      else $error("compare buffer changed outside period match");
   AST_SET_AT_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_restart |=> (chan_out_r and (!sleep_i |=> pwm_pin_o == !$past(output_invert))))
      else $error("output not set at period restart");
   AST_CLEAR_AT_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!sleep_i && !period_end && time_base == duty_buf_r) |=> !chan_out_r)
      else $error("output not cleared at duty match");
   AST_SLEEP_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sleep_i && pwm_unit_enable) |=> $stable(chan_out_r) && $stable(pwm_pin_o))
      else $error("channel moved in sleep");
   AST_ENABLE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pwm_unit_enable && !sleep_i && !period_end && time_base != duty_buf_r) |=> chan_out_r == $past(chan_out_r))
      else $error("enabled channel changed without cause");
endmodule : pwmc_channel

// ---- verif/pwmc_timer_model.sv ----
// shared period timer model: prescale tick, phase tracker and 8-bit count
module pwmc_timer_model #(
   parameter int PRE = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sleep_i,
   input wire pwmc_pkg::pwmc_byte_t period_limit_i,
   output pwmc_pkg::pwmc_byte_t count_o,
   output logic tick_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import pwmc_pkg::*;
   int div_r;
   logic [1:0] phase_r;
   // one-cycle tick every PRE clocks
   assign tick_o = (div_r == PRE - 1);
   // everything stops in sleep so the channel resumes from the same time base
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= 0;
         phase_r <= 2'h0;
         count_o <= 8'h00;
      end else if (!sleep_i) begin
         div_r <= tick_o ? 0 : div_r + 1;
         if (tick_o) begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h3) begin
               count_o <= (count_o == period_limit_i) ? 8'h00 : count_o + 8'h01;
            end
         end
      end
   end
endmodule : pwmc_timer_model

// ---- verif/test_pwm_channel_control_regs.sv ----
// self-checking bench of the pwm channel registers and waveform
`include "pwmc_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_pwm_channel_control_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import pwmc_pkg::*;
   typedef struct {pwmc_byte_t dch; pwmc_byte_t dcl; pwmc_byte_t ctl; pwmc_byte_t rb; int hi;} pwmc_row_s;
   // limit 3, tick every 2 clocks: 32-clock period, 128 clocks measured
   // duty 6 gives 13 high clocks: the clear lands on the edge after the match is seen
   pwmc_row_s rows [7] = '{'{8'h01, 8'h80, 8'hC0, 8'h80, 52}, '{8'h01, 8'hBF, 8'h80, 8'h80, 52},
      '{8'h01, 8'h80, 8'hD0, 8'h80, 76}, '{8'h04, 8'h00, 8'hC0, 8'h00, 128},
      '{8'h00, 8'h00, 8'hC0, 8'h00, 0}, '{8'h01, 8'h80, 8'h40, 8'h80, 0}, '{8'h01, 8'h80, 8'h50, 8'h80, 128}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   pwmc_addr_t addr_i = 2'h0;
   pwmc_byte_t wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sleep_i = 1'b0;
   pwmc_byte_t period_limit_i = 8'h03;
   pwmc_byte_t rdata_o, count_w;
   logic tick_w, pwm_pin_o, pwm_pin_oe_o, p;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int hi;
   pwmc_byte_t d;
   always #2 clk_i = ~clk_i;
   pwmc_timer_model #(.PRE(2)) u_tmr (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_i(sleep_i),
      .period_limit_i(period_limit_i), .count_o(count_w), .tick_o(tick_w));
   pwmc_channel u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .period_timer_count_i(count_w), .period_limit_i(period_limit_i),
      .prescale_tick_i(tick_w), .sleep_i(sleep_i), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o));
   task automatic stop_test();
      $display("errors=%0d tests=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // one-cycle write strobe
   task automatic wr(input pwmc_addr_t a, input pwmc_byte_t v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // data is taken in the single cycle after the strobe
   task automatic rd(input pwmc_addr_t a, output pwmc_byte_t v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd
   // high clocks of the pin over four whole periods, start phase does not matter
   task automatic measure(output int h);
      h = 0;
      repeat (128) begin
         @(posedge clk_i);
         #1 if (pwm_pin_o === 1'b1) h++;
      end
   endtask : measure
   // hang guard, generous against roughly 1760 expected clocks
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         wr(`PWMC_OFF_DCH, rows[i].dch);
         wr(`PWMC_OFF_DCL, rows[i].dcl);
         wr(`PWMC_OFF_CTRL, rows[i].ctl);
         rd(`PWMC_OFF_DCL, d);
         `CHK(d, rows[i].rb)
         `CHK(pwm_pin_oe_o, rows[i].ctl[6])
         repeat (64) @(posedge clk_i);
         measure(hi);
         `CHK(hi, rows[i].hi)
      end
      // flag and low control bits cannot be written; unmapped offset is dead
      wr(`PWMC_OFF_CTRL, 8'h2F);
      wr(2'h3, 8'hFF);
      rd(`PWMC_OFF_CTRL, d);
      `CHK(d, 8'h00)
      rd(2'h3, d);
      `CHK(d, 8'h00)
      // disabled and inverted: flag follows the inactive pin level
      wr(`PWMC_OFF_CTRL, 8'h10);
      repeat (3) @(posedge clk_i);
      rd(`PWMC_OFF_CTRL, d);
      `CHK(d, 8'h30)
      // sleep freezes the pin mid-run, wake resumes the same waveform
      wr(`PWMC_OFF_DCH, 8'h01);
      wr(`PWMC_OFF_DCL, 8'h80);
      wr(`PWMC_OFF_CTRL, 8'hC0);
      repeat (70) @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 p = pwm_pin_o;
      hi = 0;
      repeat (40) begin
         @(posedge clk_i);
         #1 if (pwm_pin_o !== p) hi++;
      end
      `CHK(hi, 0)
      @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (64) @(posedge clk_i);
      measure(hi);
      `CHK(hi, 52)
      // reset clears control but keeps the duty bytes
      wr(`PWMC_OFF_DCH, 8'h5A);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 `CHK(pwm_pin_oe_o, 1'b0)
      `CHK(pwm_pin_o, 1'b0)
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`PWMC_OFF_CTRL, d);
      `CHK(d, 8'h00)
      rd(`PWMC_OFF_DCH, d);
      `CHK(d, 8'h5A)
      stop_test();
   end
endmodule : test_pwm_channel_control_regs
